/* shared/echo_defines.vh */
`ifndef ECHO_DEFINES_VH
`define ECHO_DEFINES_VH

`define CLK_PERIOD_NS 10
`define CLAIM_DECODE_NS 20

`define SLOT_COUNT 3
`define ECHO_FIFO_DEPTH 4
`define ECHO_FIFO_WIDTH 16

`define BOARD_ID_RESET 5'h0a

`define ST_IDLE 3'h0
`define ST_DECODE 3'h1
`define ST_PUSH 3'h2
`define ST_START 3'h3
`define ST_WAIT 3'h4
`define ST_RETURN 3'h5
`define ST_DONE 3'h6

`endif

/* src/echo_fifo.v */
`timescale 1ns/10ps
`include "echo_defines.vh"
module echo_fifo #(
  parameter WIDTH = `ECHO_FIFO_WIDTH,
  parameter DEPTH = `ECHO_FIFO_DEPTH
) (
  input wire clk_sys,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  function integer clog2;
    input integer value;
    integer v;
    begin
      v = value - 1;
      clog2 = 1;
      while (v > 1) begin
        v = v >> 1;
        clog2 = clog2 + 1;
      end
    end
  endfunction

  localparam PW = clog2(DEPTH);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] wr_ptr;
  reg [PW-1:0] rd_ptr;
  reg [PW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[PW:0]);
  assign out_valid = (count != {(PW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= {PW{1'b0}};
      rd_ptr <= {PW{1'b0}};
      count <= {(PW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* src/isa_dma_local_bus_echo.v */
// Contract
// - Watch system bus strobes and follow DMA/master transfers to local targets.
// - Memory/IO indicator high for memory read or write strobes, else low.
// - Write/read indicator high for memory or IO write strobes, low for reads.
// - With AEN set and no refresh, drive DMA address onto local address lines (AEN is not checked; any strobe starts it).
// - Refresh cycles are ignored and never echoed on the local bus.
// - Pull IOCHRDY low as soon as a local target is recognised.
// - Release IOCHRDY when the local target asserts its ready.
// - Drive SA, LA and SBHE back onto local address during DMA/master cycles.
// - On memory write, local data lines carry the SD value.
// - On memory read, SD carries data returned from the local bus.
// - Assert MEMCS16 for every DMA/master memory transfer to a local target.
// - When controller owns the bus, drive address, strobe, enables, type lines.
// - Under a slot master, receive its lines; keep clock, reset, ready, id, grant.
// - Claim, request and grant are one separate line per slot.
// - Wide transfers reuse upper address and enable pins; request/ack handshake (unused: only 16-bit echoes).
// - Sample combined slot claim to decide whether the access is forwarded.
// - Ready return follows target ready by some cycles; target holds read data.
`timescale 1ns/10ps
`include "echo_defines.vh"
module isa_dma_local_bus_echo #(
  parameter SLOTS = `SLOT_COUNT,
  parameter FIFO_DEPTH = `ECHO_FIFO_DEPTH,
  parameter [4:0] BOARD_ID = `BOARD_ID_RESET
) (
  input wire clk_sys,
  input wire rst,
  input wire memr_n,
  input wire memw_n,
  input wire ior_n,
  input wire iow_n,
  input wire aen,
  input wire refresh_n,
  input wire [16:0] sa,
  input wire [23:17] la,
  input wire sbhe_n,
  input wire [15:0] sd_in,
  output reg [15:0] sd_out,
  output reg sd_oe,
  output wire iochrdy_out,
  output reg iochrdy_oe,
  output wire memcs16_n_out,
  output reg memcs16_n_oe,
  output wire local_bus_clock,
  output reg local_reset_n,
  output reg [31:2] adr_out,
  output reg adr_oe,
  output reg [3:0] be_n,
  output reg ads_n,
  output reg m_io,
  output reg w_r,
  output reg d_c_n,
  output reg blast_n,
  output reg cache_invalidate_strobe_n,
  output reg ctrl_oe,
  input wire [31:0] dat_in,
  output reg [31:0] dat_out,
  output reg dat_oe,
  input wire target_ready_n,
  input wire half_width_size_n,
  input wire wide_transfer_ack_n,
  output reg wide_transfer_request_n,
  output reg ready_return_n,
  output reg write_back_n,
  output reg [4:0] board_identification,
  input wire [SLOTS-1:0] slot_claim_n,
  input wire [SLOTS-1:0] slot_bus_request_n,
  output reg [SLOTS-1:0] slot_bus_grant_n
);
  // 20 ns decode allowance, rounded up to whole cycles
  localparam integer CLAIM_CYCLES =
    (`CLAIM_DECODE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [1:0] CLAIM_LAST = CLAIM_CYCLES[1:0] - 2'h1;

  function [3:0] lane_be_n;
    input a1;
    input a0;
    input bhe_n;
    reg [1:0] pair;
    begin
      pair = {bhe_n, a0};
      lane_be_n = a1 ? {pair, 2'h3} : {2'h3, pair};
    end
  endfunction

  reg [2:0] state;
  reg [1:0] claim_cnt;
  reg is_mem;
  reg is_write;
  reg [3:0] cyc_be_n;
  reg cyc_a1;
  reg ready_seen;
  reg slot_master_active;
  reg target_ready_q;

  wire any_strobe;
  wire strobe_mem;
  wire strobe_write;
  wire refresh_cycle;
  wire claimed;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire fifo_push;
  wire fifo_pop;
  wire [15:0] lane_data;

  assign any_strobe = !memr_n || !memw_n || !ior_n || !iow_n;
  assign strobe_mem = !memr_n || !memw_n;
  assign strobe_write = !memw_n || !iow_n;
  assign refresh_cycle = !refresh_n;
  assign claimed = !(&slot_claim_n);
  assign local_bus_clock = clk_sys;
  assign iochrdy_out = 1'b0;
  assign memcs16_n_out = 1'b0;

  assign fifo_push = (state == `ST_PUSH) && fifo_in_ready;
  assign fifo_pop = (state == `ST_START) && is_write;
  // Upper half of the local data word when address bit 1 is set
  assign lane_data = cyc_a1 ? dat_in[31:16] : dat_in[15:0];

  echo_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) write_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(sd_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Lowest requesting slot wins unless the holder still requests; taken away while a system bus command is pending
  integer i;
  reg [SLOTS-1:0] next_grant_n;
  reg found;
  always @* begin
    next_grant_n = {SLOTS{1'b1}};
    found = 1'b0;
    if (!any_strobe && state == `ST_IDLE) begin
      for (i = 0; i < SLOTS; i = i + 1) begin
        if (!found && !slot_bus_grant_n[i] && !slot_bus_request_n[i]) begin
          next_grant_n[i] = 1'b0;
          found = 1'b1;
        end
      end
      for (i = 0; i < SLOTS; i = i + 1) begin
        if (!found && !slot_bus_request_n[i]) begin
          next_grant_n[i] = 1'b0;
          found = 1'b1;
        end
      end
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      slot_bus_grant_n <= {SLOTS{1'b1}};
      slot_master_active <= 1'b0;
      local_reset_n <= 1'b0;
      board_identification <= 5'h00;
      write_back_n <= 1'b1;
      target_ready_q <= 1'b1;
    end else begin
      slot_bus_grant_n <= next_grant_n;
      slot_master_active <= !(&next_grant_n);
      local_reset_n <= 1'b1;
      board_identification <= BOARD_ID;
      write_back_n <= 1'b1;
      target_ready_q <= target_ready_n;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      state <= `ST_IDLE;
      claim_cnt <= 2'h0;
      is_mem <= 1'b0;
      is_write <= 1'b0;
      cyc_be_n <= 4'hf;
      cyc_a1 <= 1'b0;
      ready_seen <= 1'b0;
      sd_out <= 16'h0000;
      sd_oe <= 1'b0;
      iochrdy_oe <= 1'b0;
      memcs16_n_oe <= 1'b0;
      adr_out <= 30'h00000000;
      adr_oe <= 1'b0;
      be_n <= 4'hf;
      ads_n <= 1'b1;
      m_io <= 1'b0;
      w_r <= 1'b0;
      d_c_n <= 1'b1;
      blast_n <= 1'b1;
      cache_invalidate_strobe_n <= 1'b1;
      ctrl_oe <= 1'b0;
      dat_out <= 32'h00000000;
      dat_oe <= 1'b0;
      wide_transfer_request_n <= 1'b1;
      ready_return_n <= 1'b1;
    end else begin
      ads_n <= 1'b1;
      cache_invalidate_strobe_n <= 1'b1;
      // Only 16-bit echoes, so the wide request stays idle
      wide_transfer_request_n <= 1'b1;
      ready_return_n <= 1'b1;
      case (state)
        `ST_IDLE: begin
          // Slot master drives the address and type lines itself
          ready_return_n <= slot_master_active ? target_ready_q : 1'b1;
          adr_oe <= 1'b0;
          ctrl_oe <= 1'b0;
          dat_oe <= 1'b0;
          if (any_strobe && !refresh_cycle && !slot_master_active) begin
            state <= `ST_DECODE;
            claim_cnt <= 2'h0;
            is_mem <= strobe_mem;
            is_write <= strobe_write;
            cyc_a1 <= sa[1];
            cyc_be_n <= lane_be_n(sa[1], sa[0], sbhe_n);
            adr_out <= {8'h00, la, sa[16:2]};
            adr_oe <= 1'b1;
            ctrl_oe <= 1'b1;
            be_n <= lane_be_n(sa[1], sa[0], sbhe_n);
            m_io <= strobe_mem;
            w_r <= strobe_write;
            d_c_n <= 1'b1;
            blast_n <= 1'b0;
          end
        end
        `ST_DECODE: begin
          if (refresh_cycle || !any_strobe) begin
            state <= `ST_DONE;
          end else if (claim_cnt == CLAIM_LAST) begin
            if (claimed) begin
              iochrdy_oe <= 1'b1;
              memcs16_n_oe <= is_mem;
              state <= is_write ? `ST_PUSH : `ST_START;
            end else begin
              state <= `ST_DONE;
            end
          end else begin
            claim_cnt <= claim_cnt + 2'h1;
          end
        end
        `ST_PUSH: begin
          // A full FIFO holds the cycle here while IOCHRDY keeps SD stretched
          if (fifo_in_ready) begin
            state <= `ST_START;
          end
        end
        `ST_START: begin
          if (!is_write || fifo_out_valid) begin
            ads_n <= 1'b0;
            cache_invalidate_strobe_n <= !is_mem;
            if (is_write) begin
              dat_out <= {fifo_out_data, fifo_out_data};
              dat_oe <= 1'b1;
            end
            state <= `ST_WAIT;
          end
        end
        `ST_WAIT: begin
          if (!target_ready_n) begin
            iochrdy_oe <= 1'b0;
            state <= `ST_RETURN;
          end
        end
        `ST_RETURN: begin
          // Resynchronised answer; target keeps read data until this edge
          ready_return_n <= 1'b0;
          if (!is_write) begin
            sd_out <= lane_data;
            sd_oe <= 1'b1;
          end
          state <= `ST_DONE;
        end
        `ST_DONE: begin
          adr_oe <= 1'b0;
          ctrl_oe <= 1'b0;
          dat_oe <= 1'b0;
          blast_n <= 1'b1;
          iochrdy_oe <= 1'b0;
          if (!any_strobe) begin
            sd_oe <= 1'b0;
            memcs16_n_oe <= 1'b0;
            state <= `ST_IDLE;
          end
        end
        default: begin
          state <= `ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* testbench/echo_sva.sv */
`timescale 1ns/10ps
module echo_sva #(
  parameter SLOTS = 3
) (
  input wire clk_sys,
  input wire rst,
  input wire memr_n,
  input wire memw_n,
  input wire iow_n,
  input wire refresh_n,
  input wire [16:0] sa,
  input wire [23:17] la,
  input wire [15:0] sd_in,
  input wire iochrdy_oe,
  input wire memcs16_n_oe,
  input wire [31:2] adr_out,
  input wire adr_oe,
  input wire ads_n,
  input wire m_io,
  input wire w_r,
  input wire cache_invalidate_strobe_n,
  input wire [31:0] dat_out,
  input wire dat_oe,
  input wire target_ready_n,
  input wire ready_return_n,
  input wire [SLOTS-1:0] slot_claim_n,
  input wire [SLOTS-1:0] slot_bus_grant_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rfsh; !ads_n |-> refresh_n; endproperty
  a_rfsh: assert property (p_rfsh) else $error("start in refresh");
  property p_mio; !ads_n |-> m_io == (!memr_n || !memw_n); endproperty
  a_mio: assert property (p_mio) else $error("m_io wrong");
  property p_wr; !ads_n |-> w_r == (!memw_n || !iow_n); endproperty
  a_wr: assert property (p_wr) else $error("w_r wrong");
  property p_adr; adr_oe |-> adr_out == {8'h00, la, sa[16:2]}; endproperty
  a_adr: assert property (p_adr) else $error("address wrong");
  property p_claim; $rose(iochrdy_oe) |-> !(&$past(slot_claim_n)); endproperty
  a_claim: assert property (p_claim) else $error("wait without claim");
  property p_wait; !ads_n |-> iochrdy_oe; endproperty
  a_wait: assert property (p_wait) else $error("no wait state");
  property p_rel; iochrdy_oe && !target_ready_n |=> !iochrdy_oe; endproperty
  a_rel: assert property (p_rel) else $error("wait not released");
  property p_cs16; iochrdy_oe && (!memr_n || !memw_n) |-> memcs16_n_oe; endproperty
  a_cs16: assert property (p_cs16) else $error("chip select missing");
  property p_rtn; iochrdy_oe && !target_ready_n |-> ##[1:2] !ready_return_n; endproperty
  a_rtn: assert property (p_rtn) else $error("no ready return");
  property p_wdat; dat_oe |-> dat_out == {sd_in, sd_in}; endproperty
  a_wdat: assert property (p_wdat) else $error("write data wrong");
  property p_gnt; $onehot0(~slot_bus_grant_n); endproperty
  a_gnt: assert property (p_gnt) else $error("two grants");
  property p_inv; !cache_invalidate_strobe_n |-> !ads_n && m_io; endproperty
  a_inv: assert property (p_inv) else $error("invalidate misplaced");
  c_wr: cover property (!ads_n && w_r);
  c_io: cover property (!ads_n && !m_io);
  c_gnt: cover property (!(&slot_bus_grant_n));
endmodule

/* testbench/local_target.sv */
`timescale 1ns/10ps
module local_target (
  input wire clk_sys,
  input wire ads_n,
  input wire adr_oe,
  input wire [31:2] adr_out,
  input wire dat_oe,
  input wire [31:0] dat_out,
  input wire ready_return_n,
  input wire [3:0] dly,
  output wire [2:0] slot_claim_n,
  output logic target_ready_n = 1'b1,
  output logic [31:0] dat_in = 32'h0,
  output logic [31:0] wr_data = 32'h0
);
  logic busy = 1'b0;
  logic [3:0] cnt = 4'h0;
  // Decode only slot 0; other slots stay unclaimed
  assign slot_claim_n = {2'b11, !(adr_oe && adr_out[23:20] == 4'h5)};
  always @(posedge clk_sys) begin
    target_ready_n <= 1'b1;
    if (!ads_n && !slot_claim_n[0]) begin
      busy <= 1'b1;
      cnt <= dly;
    end else if (busy) begin
      if (cnt == 4'h0) begin
        busy <= 1'b0;
        target_ready_n <= 1'b0;
        dat_in <= {~adr_out[17:2], adr_out[17:2]};
        if (dat_oe) begin
          wr_data <= dat_out;
        end
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
    // Read data held until return seen, then scrambled
    if (!ready_return_n) begin
      dat_in <= ~dat_in;
    end
  end
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/10ps
`include "echo_defines.vh"
module tb_top;
  logic clk_sys = 0, rst = 1, memr_n = 1, memw_n = 1, ior_n = 1, iow_n = 1;
  logic aen = 0, refresh_n = 1, sbhe_n = 0, half_width_size_n = 1, wide_transfer_ack_n = 1;
  logic [16:0] sa = 0;
  logic [23:17] la = 0;
  logic [15:0] sd_drv = 0;
  logic [3:0] dly = 0;
  logic [2:0] slot_bus_request_n = 3'h7;
  wire [15:0] sd_in, sd_out;
  wire [31:0] dat_in, dat_out, wr_data;
  wire [31:2] adr_out;
  wire [3:0] be_n;
  wire [4:0] board_identification;
  wire [2:0] slot_claim_n, slot_bus_grant_n;
  wire sd_oe, iochrdy_out, iochrdy_oe, memcs16_n_out, memcs16_n_oe, local_bus_clock;
  wire local_reset_n, adr_oe, ads_n, m_io, w_r, d_c_n, blast_n, ctrl_oe, dat_oe;
  wire cache_invalidate_strobe_n, target_ready_n, wide_transfer_request_n;
  wire ready_return_n, write_back_n;
  int num_errors = 0, checked = 0;
  assign sd_in = sd_oe ? sd_out : sd_drv;
  always #5 clk_sys = ~clk_sys;
  isa_dma_local_bus_echo uut (.*);
  local_target tgt (.*);
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // 0: ads_n, 1: ready_return_n
  task automatic wt(int w);
    for (int i = 0; i < 40; i++) begin
      if ((w == 0 ? ads_n : ready_return_n) === 1'b0) return;
      tick(1);
    end
    cmp("wait", 0, 1);
    test_done();
  endtask
  // k: 0 memory read, 1 memory write, 2 io read, 3 io write
  task automatic cyc(int k, logic [23:0] a, logic [15:0] d, logic cl);
    {la, sa} = a;
    sd_drv = d;
    aen = 1;
    {iow_n, ior_n, memw_n, memr_n} = ~(4'h1 << k);
    if (cl) begin
      wt(0);
      cmp("m_io", k < 2, m_io);
      cmp("w_r", k % 2, w_r);
      cmp("adr", {8'h00, a[23:2]}, adr_out);
      cmp("be_n", a[1] ? {sbhe_n, a[0], 2'h3} : {2'h3, sbhe_n, a[0]}, be_n);
      cmp("invalidate", k > 1, cache_invalidate_strobe_n);
      cmp("memcs16", k < 2, memcs16_n_oe);
      cmp("iochrdy", 1, iochrdy_oe);
      wt(1);
      cmp("iochrdy released", 0, iochrdy_oe);
      if (k == 0) cmp("sd drive", 1, sd_oe);
      if (k == 0) cmp("sd", a[1] ? {~a[17:2]} : a[17:2], sd_out);
      if (k == 1) cmp("wr_data", {d, d}, wr_data);
    end else begin
      tick(4);
      cmp("unclaimed wait", 0, iochrdy_oe);
      cmp("unclaimed adr", 0, adr_oe);
      tick(8);
    end
    {iow_n, ior_n, memw_n, memr_n} = 4'hf;
    aen = 0;
    tick(4);
    cmp("sd released", 0, sd_oe);
  endtask
  task automatic t_reset;
    cmp("id", `BOARD_ID_RESET, board_identification);
    cmp("local reset", 1, local_reset_n);
    cmp("write back", 1, write_back_n);
    cmp("wide req", 1, wide_transfer_request_n);
  endtask
  task automatic t_kinds;
    for (int k = 0; k < 4; k++) cyc(k, 24'h5a2344 + k * 4, 16'h3c51 + k, 1);
  endtask
  task automatic t_slow;
    dly = 5;
    cyc(0, 24'h51fffe, 16'h0, 1);
    cyc(1, 24'h534ab8, 16'hbe07, 1);
    dly = 0;
  endtask
  task automatic t_refused;
    cyc(0, 24'h2a0010, 16'h0, 0);
    refresh_n = 0;
    cyc(0, 24'h500020, 16'h0, 0);
    refresh_n = 1;
  endtask
  task automatic t_grant;
    slot_bus_request_n = 3'b101;
    tick(2);
    cmp("grant one", 3'b101, slot_bus_grant_n);
    slot_bus_request_n = 3'b111;
    tick(2);
    cmp("grant none", 3'b111, slot_bus_grant_n);
    slot_bus_request_n = 3'b100;
    tick(2);
    cmp("grant low", 3'b110, slot_bus_grant_n);
    // Pending system command takes the bus back from the slot master
    cyc(1, 24'h5a0100, 16'h1234, 1);
    cmp("grant again", 3'b110, slot_bus_grant_n);
    slot_bus_request_n = 3'b111;
    tick(3);
  endtask
  initial begin
    tick(6);
    rst = 0;
    tick(2);
    t_reset();
    t_kinds();
    t_slow();
    t_refused();
    t_grant();
    test_done();
  end
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
endmodule
bind isa_dma_local_bus_echo echo_sva #(.SLOTS(SLOTS)) chk (.*);
